// ### shared/sacc_pkg.sv
// Function
// - Result is ten bits over two bytes, right or left adjusted.
// - Reading the low byte blocks result updates until the high byte is read.
// - Reading the high byte lifts the update block.
// - Completion flag is set even when the result is discarded.
// - Start bit begins one conversion, stays one, clears on completion.
// - A channel change during a conversion waits for its end.
// - Selections apply only while enabled; disabled means no analog power.
// - Auto-trigger edge resets the prescaler and starts a conversion.
// - Edges during a conversion and levels at completion start nothing.
// - Flag used as trigger must be cleared by software between events.
// - Completion flag as trigger chains conversions; software starts the first.
// - Start bit reads one when busy; writing it starts even under auto-trigger.
// - Prescaler runs while enabled, held reset otherwise, ratio from field.
// - A start bit write begins at the next conversion clock rising edge.
// - Normal conversion is 13 cycles; the first after enable is 25.
// - Sampling at 1.5 cycles normally and 13.5 cycles on the first.
// - Completion writes result, sets flag, clears start bit in single mode.
// - Triggered conversion samples 2 cycles after the edge, lasts 13.5.
// - Free running restarts at once with the start bit kept high.
// - Input select picks one of eight pins, ground or bandgap.
// - Reference select picks analog supply, internal 1.1V or reference pin.
// - Selections buffered, frozen during conversion, reopened in last cycle.
package sacc_pkg;
  typedef enum logic [0:0] {
    SACC_IDLE = 1'b0,
    SACC_CONV = 1'b1
  } sacc_state_e;
  // Register indices on the three-bit address port.
  localparam logic [2:0] ADDR_RESULT_LOW  = 3'h0;
  localparam logic [2:0] ADDR_RESULT_HIGH = 3'h1;
  localparam logic [2:0] ADDR_CONTROL_A   = 3'h2;
  localparam logic [2:0] ADDR_CONTROL_B   = 3'h3;
  localparam logic [2:0] ADDR_INPUT_SEL   = 3'h4;
  localparam logic [2:0] ADDR_POWER       = 3'h5;
  // Field positions in conv_control_a and input_select_reg.
  localparam int BIT_ENABLE = 7;
  localparam int BIT_START  = 6;
  localparam int BIT_AUTO   = 5;
  localparam int BIT_FLAG   = 4;
  localparam int BIT_LEFT   = 5;
  localparam int POS_REF    = 6;
  // Reset values.
  localparam logic       POWER_REDUCE_RST = 1'b1;
  localparam logic [3:0] CHAN_RST         = 4'h0;
  // Trigger select value that chains on the completion flag.
  localparam logic [2:0] TRIG_FREE_RUN = 3'h0;
  // Conversion timing in conversion clock cycles.
  localparam logic [4:0] NORMAL_LEN    = 5'h0d;
  localparam logic [4:0] FIRST_LEN     = 5'h19;
  localparam logic [4:0] NORMAL_SAMPLE = 5'h01;
  localparam logic [4:0] FIRST_SAMPLE  = 5'h0d;
  localparam logic [4:0] AUTO_SAMPLE   = 5'h01;
  localparam logic [4:0] AUTO_END      = 5'h0d;
  // Prescale select 0 and 1 divide by two, n above divides by two to the n.
  function automatic logic [7:0] divisor(input logic [2:0] sel);
    divisor = (sel == 3'h0) ? 8'h02 : (8'h01 << sel);
  endfunction : divisor
endpackage : sacc_pkg

// ### shared/sacc_link_if.sv
`timescale 1ns/1ns
interface sacc_link_if;
  logic       run;
  logic       restart;
  logic [2:0] divSel;
  logic       tick;
  logic       fallTick;
  logic [6:0] trigRaw;
  logic [2:0] trigSel;
  logic       trigEdge;
  modport ctrl  (output run, restart, divSel, trigRaw, trigSel,
                 input tick, fallTick, trigEdge);
  modport presc (input run, restart, divSel, output tick, fallTick);
  modport trig  (input trigRaw, trigSel, output trigEdge);
endinterface : sacc_link_if

// ### hw/sacc_prescaler.sv
`timescale 1ns/1ns
module sacc_prescaler (
  input wire logic clk,
  input wire logic rst_n,
  sacc_link_if.presc lnk
);
  logic [7:0] cnt_reg;
  logic [7:0] div;
  assign div = sacc_pkg::divisor(lnk.divSel);
  // Counter is held at zero while disabled or on a trigger restart.
  always_ff @(posedge clk) begin
    if (!rst_n || !lnk.run || lnk.restart) begin
      cnt_reg <= 8'h00;
    end else if (cnt_reg == div - 8'h01) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
  // Rising edge ends the period, falling edge lies at its middle.
  assign lnk.tick     = lnk.run && !lnk.restart && (cnt_reg == div - 8'h01);
  assign lnk.fallTick = lnk.run && !lnk.restart && (cnt_reg == (div >> 1) - 8'h01);
endmodule : sacc_prescaler

// ### hw/sacc_trigger.sv
`timescale 1ns/1ns
module sacc_trigger (
  input wire logic clk,
  input wire logic rst_n,
  sacc_link_if.trig lnk
);
  logic [6:0] sync1_reg;
  logic [6:0] sync2_reg;
  logic       prev_reg;
  logic       edge_reg;
  logic [7:0] srcs;
  logic       cur;
  // Source 0 is the internal chain, so a constant zero fills its slot.
  assign srcs = {sync2_reg, 1'b0};
  assign cur  = srcs[lnk.trigSel];
  // Two stages of synchronisation plus the edge stage give three cycles.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_reg <= 7'h00;
      sync2_reg <= 7'h00;
      prev_reg  <= 1'b0;
      edge_reg  <= 1'b0;
    end else begin
      sync1_reg <= lnk.trigRaw;
      sync2_reg <= sync1_reg;
      prev_reg  <= cur;
      edge_reg  <= cur && !prev_reg;
    end
  end
  assign lnk.trigEdge = edge_reg;
endmodule : sacc_trigger

// ### hw/sacc_top.sv
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ns
module sacc_top (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wrData,
  input  wire logic       wrStrobe,
  input  wire logic       rdStrobe,
  output logic      [7:0] rdData,
  input  wire logic [6:0] trigIn,
  input  wire logic [9:0] resultIn,
  output logic            analogPower,
  output logic            sampleHold,
  output logic            convBusy,
  output logic      [3:0] chanApplied,
  output logic      [1:0] refApplied,
  output logic            doneFlag,
  output logic            convDone
);
  sacc_link_if link ();

  sacc_prescaler uPresc (
    .clk   (clk),
    .rst_n (rst_n),
    .lnk   (link.presc)
  );

  sacc_trigger uTrig (
    .clk   (clk),
    .rst_n (rst_n),
    .lnk   (link.trig)
  );

  // Software-visible control state.
  logic       enable_reg;
  logic       auto_reg;
  logic [2:0] prescale_reg;
  logic       flag_reg;
  logic [2:0] trigSel_reg;
  logic [3:0] chan_reg;
  logic [1:0] ref_reg;
  logic       left_reg;
  logic       powerReduce_reg;
  // Sequencer state.
  sacc_pkg::sacc_state_e state_reg;
  logic       startReq_reg;
  logic [4:0] cycCnt_reg;
  logic       first_reg;
  logic       autoConv_reg;
  logic       lock_reg;
  logic [9:0] result_reg;
  logic [3:0] chanApplied_reg;
  logic [1:0] refApplied_reg;
  logic       sample_reg;
  logic       done_reg;
  logic [7:0] rdData_reg;
  logic [7:0] rdData_next;

  // Decoded strobes and derived conditions.
  logic       wrA;
  logic       rdLow;
  logic       rdHigh;
  logic       effEnable;
  logic       freeRun;
  logic       busy;
  logic       startWrite;
  logic       tickStart;
  logic       trigStart;
  logic       anyStart;
  logic       lastCycle;
  logic       endNow;
  logic       sampleNow;
  logic       startView;
  logic [4:0] endCnt;

  // One address compare serves every write decode and the result-byte read strobes; the read mux uses a case on addr.
  function automatic logic hit(input logic [2:0] a, input logic [2:0] idx);
    hit = (a == idx);
  endfunction : hit

  assign wrA    = wrStrobe && hit(addr, sacc_pkg::ADDR_CONTROL_A);
  assign rdLow  = rdStrobe && hit(addr, sacc_pkg::ADDR_RESULT_LOW);
  assign rdHigh = rdStrobe && hit(addr, sacc_pkg::ADDR_RESULT_HIGH);

  // The power-reduce bit overrides enable, so a set bit keeps all idle.
  assign effEnable = enable_reg && !powerReduce_reg;
  assign freeRun   = auto_reg && (trigSel_reg == sacc_pkg::TRIG_FREE_RUN);
  assign busy      = (state_reg == sacc_pkg::SACC_CONV);

  // Start bit writes count only when enabled; busy writes change nothing except in a single-mode completion cycle.
  assign startWrite = wrA && wrData[sacc_pkg::BIT_START] && effEnable;
  // A pending start waits for the next conversion clock rising edge.
  assign tickStart  = !busy && startReq_reg && link.tick && effEnable;
  // Only an idle converter honours a trigger edge.
  assign trigStart  = !busy && effEnable && auto_reg && !freeRun
                      && link.trigEdge;
  assign anyStart   = tickStart || trigStart;

  // Final count index; the first conversion always uses the long timing.
  always_comb begin
    if (first_reg) begin
      endCnt = sacc_pkg::FIRST_LEN - 5'h01;
    end else if (autoConv_reg) begin
      endCnt = sacc_pkg::AUTO_END;
    end else begin
      endCnt = sacc_pkg::NORMAL_LEN - 5'h01;
    end
  end

  assign lastCycle = busy && (cycCnt_reg == endCnt);

  // Triggered conversions other than the first end on a falling edge, giving the half cycle.
  always_comb begin
    if (!busy) begin
      endNow = 1'b0;
    end else if (autoConv_reg && !first_reg) begin
      endNow = link.fallTick && (cycCnt_reg == endCnt);
    end else begin
      endNow = link.tick && (cycCnt_reg == endCnt);
    end
  end

  // Sampling point per conversion kind.
  always_comb begin
    if (!busy) begin
      sampleNow = 1'b0;
    end else if (first_reg) begin
      sampleNow = link.fallTick && (cycCnt_reg == sacc_pkg::FIRST_SAMPLE);
    end else if (autoConv_reg) begin
      sampleNow = link.tick && (cycCnt_reg == sacc_pkg::AUTO_SAMPLE);
    end else begin
      sampleNow = link.fallTick && (cycCnt_reg == sacc_pkg::NORMAL_SAMPLE);
    end
  end

  // Start bit reads one whenever a conversion is pending or running.
  assign startView = startReq_reg || busy;

  // Prescaler and trigger hookup.
  assign link.run     = effEnable;
  assign link.restart = trigStart;
  assign link.divSel  = prescale_reg;
  assign link.trigRaw = trigIn;
  assign link.trigSel = trigSel_reg;

  // Control A holds enable, auto-trigger and prescale fields.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enable_reg   <= 1'b0;
      auto_reg     <= 1'b0;
      prescale_reg <= 3'h0;
    end else if (wrA) begin
      enable_reg   <= wrData[sacc_pkg::BIT_ENABLE];
      auto_reg     <= wrData[sacc_pkg::BIT_AUTO];
      prescale_reg <= wrData[2:0];
    end
  end

  // Other writable registers; input selection is only the buffer copy.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trigSel_reg     <= 3'h0;
      chan_reg        <= sacc_pkg::CHAN_RST;
      ref_reg         <= 2'h0;
      left_reg        <= 1'b0;
      powerReduce_reg <= sacc_pkg::POWER_REDUCE_RST;
    end else if (wrStrobe) begin
      if (hit(addr, sacc_pkg::ADDR_CONTROL_B)) begin
        trigSel_reg <= wrData[2:0];
      end
      if (hit(addr, sacc_pkg::ADDR_INPUT_SEL)) begin
        chan_reg <= wrData[3:0];
        ref_reg  <= wrData[sacc_pkg::POS_REF +: 2];
        left_reg <= wrData[sacc_pkg::BIT_LEFT];
      end
      if (hit(addr, sacc_pkg::ADDR_POWER)) begin
        powerReduce_reg <= wrData[0];
      end
    end
  end

  // Completion flag: hardware set beats a same-cycle software clear.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag_reg <= 1'b0;
    end else if (endNow) begin
      flag_reg <= 1'b1;
    end else if (wrA && wrData[sacc_pkg::BIT_FLAG]) begin
      flag_reg <= 1'b0;
    end
  end

  // Pending start request, dropped once the conversion has begun.
  always_ff @(posedge clk) begin
    if (!rst_n || !effEnable) begin
      startReq_reg <= 1'b0;
    end else if (anyStart) begin
      startReq_reg <= 1'b0;
    end else if (startWrite && !busy) begin
      startReq_reg <= 1'b1;
    end else if (startWrite && endNow && !freeRun) begin
      startReq_reg <= 1'b1;
    end
  end

  // Sequencer; disabling aborts any conversion in flight.
  always_ff @(posedge clk) begin
    if (!rst_n || !effEnable) begin
      state_reg    <= sacc_pkg::SACC_IDLE;
      cycCnt_reg   <= 5'h00;
      autoConv_reg <= 1'b0;
    end else begin
      case (state_reg)
        sacc_pkg::SACC_IDLE: begin
          if (anyStart) begin
            state_reg    <= sacc_pkg::SACC_CONV;
            cycCnt_reg   <= 5'h00;
            autoConv_reg <= trigStart;
          end
        end
        sacc_pkg::SACC_CONV: begin
          if (endNow && freeRun) begin
            cycCnt_reg   <= 5'h00;
            autoConv_reg <= 1'b0;
          end else if (endNow) begin
            state_reg    <= sacc_pkg::SACC_IDLE;
            autoConv_reg <= 1'b0;
          end else if (link.tick) begin
            cycCnt_reg <= cycCnt_reg + 5'h01;
          end
        end
        default: begin
          state_reg <= sacc_pkg::SACC_IDLE;
        end
      endcase
    end
  end

  // The long first conversion is owed again after every disable.
  always_ff @(posedge clk) begin
    if (!rst_n || !effEnable) begin
      first_reg <= 1'b1;
    end else if (endNow) begin
      first_reg <= 1'b0;
    end
  end

  // Result lock between a low-byte read and the following high-byte read.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lock_reg <= 1'b0;
    end else if (rdLow) begin
      lock_reg <= 1'b1;
    end else if (rdHigh) begin
      lock_reg <= 1'b0;
    end
  end

  // A low read in the completion cycle also blocks, keeping bytes paired.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      result_reg <= 10'h000;
    end else if (endNow && !lock_reg && !rdLow) begin
      result_reg <= resultIn;
    end
  end

  // Applied selections follow the buffer only when idle or in the last cycle.
  always_ff @(posedge clk) begin
    if (!rst_n || !effEnable) begin
      chanApplied_reg <= sacc_pkg::CHAN_RST;
      refApplied_reg  <= 2'h0;
    end else if (!busy || lastCycle) begin
      chanApplied_reg <= chan_reg;
      refApplied_reg  <= ref_reg;
    end
  end

  // Event outputs are registered, so they trail their cause by one cycle.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sample_reg <= 1'b0;
      done_reg   <= 1'b0;
    end else begin
      sample_reg <= sampleNow;
      done_reg   <= endNow;
    end
  end

  // Read mux; unmapped indices and idle cycles return zero.
  always_comb begin
    rdData_next = 8'h00;
    if (rdStrobe) begin
      case (addr)
        sacc_pkg::ADDR_RESULT_LOW: begin
          rdData_next = left_reg ? {result_reg[1:0], 6'h00}
                                 : result_reg[7:0];
        end
        sacc_pkg::ADDR_RESULT_HIGH: begin
          rdData_next = left_reg ? result_reg[9:2]
                                 : {6'h00, result_reg[9:8]};
        end
        sacc_pkg::ADDR_CONTROL_A: begin
          rdData_next = {enable_reg, startView, auto_reg, flag_reg,
                         1'b0, prescale_reg};
        end
        sacc_pkg::ADDR_CONTROL_B: begin
          rdData_next = {5'h00, trigSel_reg};
        end
        sacc_pkg::ADDR_INPUT_SEL: begin
          rdData_next = {ref_reg, left_reg, 1'b0, chan_reg};
        end
        sacc_pkg::ADDR_POWER: begin
          rdData_next = {7'h00, powerReduce_reg};
        end
        default: begin
          rdData_next = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdData_reg <= 8'h00;
    end else begin
      rdData_reg <= rdData_next;
    end
  end

  // Port drive.
  assign rdData      = rdData_reg;
  assign analogPower = effEnable;
  assign sampleHold  = sample_reg;
  assign convBusy    = busy;
  assign chanApplied = chanApplied_reg;
  assign refApplied  = refApplied_reg;
  assign doneFlag    = flag_reg;
  assign convDone    = done_reg;

  // Checks on the sequencer and the result path.
  a_lock_blocks_update: assert property (
    @(posedge clk) disable iff (!rst_n)
    (endNow && lock_reg) |=> $stable(result_reg))
    else $error("Locked result bytes were overwritten.");

  a_high_read_unlocks: assert property (
    @(posedge clk) disable iff (!rst_n)
    (rdHigh && !rdLow) ##1 (endNow && !rdLow) |=> (result_reg == $past(resultIn)))
    else $error("Result not taken after high byte read.");

  a_flag_on_discard: assert property (
    @(posedge clk) disable iff (!rst_n)
    endNow |=> (flag_reg && convDone))
    else $error("Completion flag missing after conversion end.");

  a_single_clears_start: assert property (
    @(posedge clk) disable iff (!rst_n)
    (endNow && !freeRun && !startWrite && effEnable) |=> !startView ##1 !convDone)
    else $error("Start bit still high after single conversion.");

  a_free_run_chains: assert property (
    @(posedge clk) disable iff (!rst_n)
    (endNow && freeRun && effEnable) |=> (busy && startView && cycCnt_reg == 5'h00))
    else $error("Free running did not restart.");

  a_trig_ignored_busy: assert property (
    @(posedge clk) disable iff (!rst_n)
    (busy && link.trigEdge && !endNow && effEnable)
      |=> (busy && (autoConv_reg == $past(autoConv_reg))))
    else $error("Trigger edge disturbed a running conversion.");

  a_disable_idles: assert property (
    @(posedge clk) disable iff (!rst_n)
    !effEnable |=> (!busy && !startReq_reg && first_reg && chanApplied == 4'h0))
    else $error("Disabled converter not idle.");

  a_sel_frozen_conv: assert property (
    @(posedge clk) disable iff (!rst_n)
    (busy && !lastCycle && effEnable && $past(busy)) |=> (!effEnable || $stable(chanApplied)))
    else $error("Channel changed during conversion.");

  a_trig_restarts_presc: assert property (
    @(posedge clk) disable iff (!rst_n)
    trigStart |=> (busy && autoConv_reg && !link.tick))
    else $error("Trigger did not start a conversion.");

  a_start_on_tick: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!busy && startReq_reg && !link.tick && !trigStart) |=> !busy)
    else $error("Conversion began off the clock edge.");

  a_first_sample_point: assert property (
    @(posedge clk) disable iff (!rst_n)
    (sampleNow && first_reg) |-> (link.fallTick && cycCnt_reg == 5'h0d) ##1 sampleHold)
    else $error("First conversion sampled at wrong time.");

  a_first_length: assert property (
    @(posedge clk) disable iff (!rst_n)
    (endNow && first_reg) |-> (cycCnt_reg == 5'h18 && link.tick) ##1 convDone)
    else $error("First conversion length wrong.");
endmodule : sacc_top

// ### verif/sacc_sar_model.sv
`timescale 1ns/1ns
module sacc_sar_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       analogPower,
  input  wire logic       sampleHold,
  input  wire logic [3:0] chanApplied,
  output logic      [9:0] resultIn
);
  logic [9:0] held;

  // The held code names the channel, so the bench can tell which input was sampled.
  // Unpowered, the array output toggles every cycle instead of keeping a stale code.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      held <= 10'h000;
    end else if (sampleHold) begin
      held <= {chanApplied, 6'h25};
    end else if (!analogPower) begin
      held <= ~held;
    end
  end

  assign resultIn = held;
endmodule : sacc_sar_model

// ### verif/sacc_top_tb.sv
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module sacc_top_tb;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wrData = 8'h00;
  logic       wrStrobe = 1'b0;
  logic       rdStrobe = 1'b0;
  logic [7:0] rdData;
  logic [6:0] trigIn = 7'h00;
  logic [9:0] resultIn;
  logic       analogPower;
  logic       sampleHold;
  logic       convBusy;
  logic [3:0] chanApplied;
  logic [1:0] refApplied;
  logic       doneFlag;
  logic       convDone;
  int         n_tests = 0;
  int         n_mismatch = 0;
  int         cyc = 0;
  logic [7:0] d;
  int         b;

  // A 20 ns period gives the 50 MHz system clock.
  always #10 clk = ~clk;

  sacc_top dut_u (.clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .trigIn(trigIn),
    .resultIn(resultIn), .analogPower(analogPower), .sampleHold(sampleHold),
    .convBusy(convBusy), .chanApplied(chanApplied), .refApplied(refApplied),
    .doneFlag(doneFlag), .convDone(convDone));

  sacc_sar_model sar_u (.clk(clk), .rst_n(rst_n), .analogPower(analogPower),
    .sampleHold(sampleHold), .chanApplied(chanApplied), .resultIn(resultIn));

  task automatic results;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  // One-cycle write strobe launched right after an edge.
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wrData <= v;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample just past that edge.
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    #1 v = rdData;
  endtask : rd

  // Waits for the next completion pulse, counting busy cycles on the way.
  task automatic waitDone(output int busy);
    int i;
    busy = 0;
    i = 0;
    do begin
      @(posedge clk);
      #1 i++;
      if (convBusy === 1'b1) busy++;
    end while (convDone !== 1'b1 && i < 3000);
    `CHK(convDone, 1'b1)
  endtask : waitDone

  // A hang is cut short well above the few hundred cycles the run needs.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      n_mismatch++;
      results();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(3'h2, d);
    `CHK(d, 8'h00)
    rd(3'h5, d);
    `CHK(d, 8'h01)
    rd(3'h6, d);
    `CHK(d, 8'h00)
    wr(3'h4, 8'h4b);
    wr(3'h2, 8'h81);
    #1 `CHK(analogPower, 1'b0)
    wr(3'h5, 8'h00);
    #1 `CHK(analogPower, 1'b1)
    // The applied selection follows one edge after power comes up.
    @(posedge clk);
    #1 `CHK(chanApplied, 4'hb)
    `CHK(refApplied, 2'h1)
    $display("test enable done");
    wr(3'h2, 8'hc1);
    rd(3'h2, d);
    `CHK(d[6], 1'b1)
    waitDone(b);
    `CHK(b >= 46 && b <= 54, 1'b1)
    `CHK(doneFlag, 1'b1)
    rd(3'h2, d);
    `CHK(d[6], 1'b0)
    rd(3'h0, d);
    `CHK(d, 8'he5)
    rd(3'h1, d);
    `CHK(d, 8'h02)
    $display("test first conversion done");
    wr(3'h4, 8'h6b);
    wr(3'h2, 8'hd1);
    waitDone(b);
    `CHK(b >= 22 && b <= 30, 1'b1)
    rd(3'h0, d);
    `CHK(d, 8'h40)
    rd(3'h1, d);
    `CHK(d, 8'hb9)
    $display("test left adjust done");
    wr(3'h4, 8'h45);
    wr(3'h2, 8'hd1);
    repeat (6) @(posedge clk);
    wr(3'h4, 8'h4b);
    #1 `CHK(chanApplied, 4'h5)
    waitDone(b);
    `CHK(chanApplied, 4'hb)
    rd(3'h0, d);
    `CHK(d, 8'h65)
    wr(3'h2, 8'hd1);
    waitDone(b);
    `CHK(doneFlag, 1'b1)
    rd(3'h1, d);
    `CHK(d, 8'h01)
    wr(3'h2, 8'hd1);
    waitDone(b);
    rd(3'h0, d);
    `CHK(d, 8'he5)
    rd(3'h1, d);
    `CHK(d, 8'h02)
    $display("test lock done");
    wr(3'h3, 8'h01);
    wr(3'h2, 8'hb1);
    @(posedge clk);
    trigIn <= 7'h01;
    waitDone(b);
    `CHK(b >= 22 && b <= 34, 1'b1)
    b = 0;
    repeat (80) begin
      @(posedge clk);
      #1 if (convBusy === 1'b1) b++;
    end
    `CHK(b, 0)
    @(posedge clk);
    trigIn <= 7'h00;
    wr(3'h2, 8'hf1);
    // A trigger edge lands inside this conversion and must be dropped.
    repeat (4) @(posedge clk);
    trigIn <= 7'h01;
    waitDone(b);
    `CHK(doneFlag, 1'b1)
    repeat (8) @(posedge clk);
    #1 `CHK(convBusy, 1'b0)
    $display("test trigger done");
    wr(3'h3, 8'h00);
    wr(3'h2, 8'hf1);
    waitDone(b);
    waitDone(b);
    `CHK(b >= 22 && b <= 30, 1'b1)
    rd(3'h2, d);
    `CHK(d[6], 1'b1)
    wr(3'h2, 8'h00);
    #1 `CHK(analogPower, 1'b0)
    repeat (2) @(posedge clk);
    #1 `CHK(convBusy, 1'b0)
    `CHK(chanApplied, 4'h0)
    $display("test free run done");
    results();
  end
endmodule : sacc_top_tb
